/* File: logic/ubm_pkg.sv */
// Constants, register map and receive-entry type of the serial buffer block.
// Assumes a 32-bit AXI4-Lite master; registers are byte-wide in the low lane, except the 12-bit baud divisor in the low two lanes.
package ubm_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned BAUD_W = 12;
  localparam logic [ADDR_W-1:0] OFS_DATA = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_FORMAT = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_BAUD = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ = 6'h14;
  // Status bit positions
  localparam int unsigned ST_RXC = 7;
  localparam int unsigned ST_TXC = 6;
  localparam int unsigned ST_TX_BUFFER_EMPTY_FLAG = 5;
  localparam int unsigned ST_FE = 4;
  localparam int unsigned ST_DOR = 3;
  localparam int unsigned ST_UPE = 2;
  localparam int unsigned ST_U2X = 1;
  localparam int unsigned ST_AFM = 0;
  // Control bit positions
  localparam int unsigned CT_RECEIVE_COMPLETE_IRQ_ENABLE = 7;
  localparam int unsigned CT_TRANSMIT_COMPLETE_IRQ_ENABLE = 6;
  localparam int unsigned CT_TX_EMPTY_IRQ_ENABLE = 5;
  localparam int unsigned CT_RECEIVER_ENABLE = 4;
  localparam int unsigned CT_TRANSMITTER_ENABLE = 3;
  localparam int unsigned CT_SZX = 2;
  localparam int unsigned CT_RX9 = 1;
  localparam int unsigned CT_TX9 = 0;
  // Frame format bit positions
  localparam int unsigned FM_PAR_EN = 5;
  localparam int unsigned FM_PAR_ODD = 4;
  localparam int unsigned FM_STOP2 = 3;
  localparam int unsigned FM_SZ_HI = 2;
  localparam int unsigned FM_SZ_LO = 1;
  localparam logic [7:0] FORMAT_MASK = 8'h3E;
  localparam int unsigned IRQ_GIE = 0;
  localparam logic [7:0] STATUS_RST = 8'h20;
  localparam logic [4:0] SAMPLES_NORMAL = 5'h10;
  localparam logic [4:0] SAMPLES_DOUBLE = 5'h08;
  localparam logic [3:0] FRAME_FIXED_BITS = 4'h2;
  localparam logic [2:0] SIZE_9BIT = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic overrun_flag;
    logic parity_error_flag;
  } ubm_rx_entry_t;

  // Data bits per character; reserved codes fall back to eight
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    case (code)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      3'h7: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  endfunction

  function automatic logic [8:0] data_mask(input logic [2:0] code);
    data_mask = 9'(~(9'h1FF << char_bits(code)));
  endfunction
endpackage

/* File: logic/ubm_rx_fifo.sv */
// Two-entry receive FIFO holding each character with its own error bits.
// Assumes the caller never pushes when full and never pops when empty.
`timescale 1ns/1ps
module ubm_rx_fifo
  import ubm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic push,
  input wire ubm_pkg::ubm_rx_entry_t push_entry,
  input wire logic pop,
  input wire logic flush,
  output ubm_pkg::ubm_rx_entry_t head,
  output logic [1:0] count
);
  import ubm_pkg::*;
  ubm_rx_entry_t mem_q [2];
  logic rd_ptr_q;
  logic [1:0] count_q;
  logic wr_ptr;

  assign wr_ptr = rd_ptr_q ^ count_q[0];
  assign head = mem_q[rd_ptr_q];
  assign count = count_q;

  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= 2'(count_q + {1'b0, push} - {1'b0, pop});
    end
  end

  // Entries need no reset; count guards every read of them
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_ptr] <= push_entry;
    end
  end
endmodule // ubm_rx_fifo

/* File: logic/ubm_serial.sv */
// Serial transceiver core: shared data port, transmit buffer, receive FIFO,
// status and enables, address filtering, behind an AXI4-Lite slave.
// Assumes rxd is synchronous to aclk and an external port mux uses the *_own outputs.
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// (RQ1) Address filter drops data frames, transmitter unaffected
// (RQ2) Nine-bit master marks addresses with ninth bit
// (RQ3) Short frames with filtering need two stops
// (RQ4) Slave software toggles filter around its data
// (RQ5) Data port writes transmit, reads receive
// (RQ6) Unused high bits ignored, read as zero
// (RQ7) Data write ignored while buffer is full
// (RQ8) Buffer loads shifter when empty and enabled
// (RQ9) Two-entry receive FIFO advances on every read
// (RQ10) Receive complete shows unread data, clears on flush
// (RQ11) Transmit complete on idle, cleared by ack or one
// (RQ12) Buffer empty flag high, including after reset
// (RQ13) Framing error follows head character stop bit
// (RQ14) Overrun when full, waiting, and new start
// (RQ15) Parity error only when checking was enabled
// (RQ16) Double speed halves samples per bit
// (RQ17) Interrupt needs enable, global enable and flag
// (RQ18) Receiver owns pin; disable flushes and invalidates
// (RQ19) Transmitter disable waits until fully drained
// (RQ20) Extension bit joins size bits for width
// (RQ21) Read received ninth bit before data
// (RQ22) Write transmit ninth bit before data
// (RQ23) Frame type is first stop or ninth bit
// (RQ24) Error bits and ninth bit kept per entry
module ubm_serial
  import ubm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ubm_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ubm_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxd,
  output logic txd,
  output logic txd_own,
  output logic rxd_own,
  input wire logic irq_tx_ack,
  output logic irq_rx,
  output logic irq_tx,
  output logic irq_tx_buffer_empty_flag
);
  import ubm_pkg::*;

  // Bus slave state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, w_data_q;
  logic [3:0] w_strb_q;
  logic [ADDR_W-1:0] aw_addr_q;
  // Software registers
  logic u2x_q, afm_q, txc_q, gie_q;
  logic receive_complete_irq_enable_q, transmit_complete_irq_enable_q, tx_empty_irq_enable_q, receiver_enable_q, transmitter_enable_q, szx_q, tx9_q;
  logic [7:0] fmt_q;
  logic [BAUD_W-1:0] baud_q, pre_q;
  // Transmitter
  logic [8:0] tx_buf_q, tx_sh_q;
  logic tx_buf_vld_q, tx_busy_q, tx_on_q, txd_q;
  logic [3:0] tx_idx_q;
  logic [4:0] tx_smp_q;
  // Receiver
  logic rx_busy_q, rx_prev_q, rx_pbit_q, hold_vld_q, dor_pend_q;
  logic [3:0] rx_idx_q;
  logic [4:0] rx_smp_q;
  logic [8:0] rx_sh_q;
  ubm_rx_entry_t hold_q;
  logic irq_rx_q, irq_tx_q, irq_tx_buffer_empty_flag_q;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_DATA) || (a == OFS_STATUS) || (a == OFS_CTRL) ||
                (a == OFS_FORMAT) || (a == OFS_BAUD) || (a == OFS_IRQ);
  endfunction

  function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] a);
    word_addr = {a[ADDR_W-1:2], 2'b00};
  endfunction

  // Bus decode
  wire aw_hs = awvalid && awready_q;
  wire w_hs = wvalid && wready_q;
  wire b_hs = bvalid_q && bready;
  wire ar_hs = arvalid && arready_q;
  wire r_hs = rvalid_q && rready;
  wire do_write = !awready_q && !wready_q && !bvalid_q;
  wire [ADDR_W-1:0] wa = word_addr(aw_addr_q);
  wire [ADDR_W-1:0] ra = word_addr(araddr);
  wire lane0 = do_write && w_strb_q[0];
  wire wr_data = lane0 && (wa == OFS_DATA);
  wire wr_status = lane0 && (wa == OFS_STATUS);
  wire wr_ctrl = lane0 && (wa == OFS_CTRL);
  wire wr_format = lane0 && (wa == OFS_FORMAT);
  wire wr_baud_lo = lane0 && (wa == OFS_BAUD);
  wire wr_baud_hi = do_write && w_strb_q[1] && (wa == OFS_BAUD);
  wire wr_irq = lane0 && (wa == OFS_IRQ);

  // Frame shape, shared by both directions
  wire [2:0] size_code = {szx_q, fmt_q[FM_SZ_HI:FM_SZ_LO]}; // see (RQ20)
  wire [3:0] nbits = char_bits(size_code);
  wire [8:0] dmask = data_mask(size_code);
  wire par_en = fmt_q[FM_PAR_EN];
  wire [4:0] spb = u2x_q ? SAMPLES_DOUBLE : SAMPLES_NORMAL; // see (RQ16)
  wire [4:0] half = spb >> 1;
  wire tick = (pre_q == '0);

  // Receive FIFO
  ubm_rx_entry_t head, push_entry;
  logic [1:0] rx_count;
  wire receive_complete_flag = (rx_count != 2'h0); // see (RQ10)
  wire fifo_full = rx_count[1];
  wire rd_data = ar_hs && (ra == OFS_DATA);
  wire pop = rd_data && receive_complete_flag; // see (RQ9)
  wire push = hold_vld_q && !fifo_full && receiver_enable_q;
  assign push_entry = '{data: hold_q.data, fe: hold_q.fe, overrun_flag: dor_pend_q, parity_error_flag: hold_q.parity_error_flag}; // see (RQ24)

  ubm_rx_fifo u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .push(push),
    .push_entry(push_entry),
    .pop(pop),
    .flush(!receiver_enable_q), // see (RQ18)
    .head(head),
    .count(rx_count)
  );

  // Transmitter
  wire tx_buffer_empty_flag = !tx_buf_vld_q; // see (RQ12)
  wire tx_take = wr_data && tx_buffer_empty_flag; // see (RQ5) see (RQ7)
  wire tx_load = tx_on_q && tx_buf_vld_q && !tx_busy_q; // see (RQ8)
  wire [3:0] tx_total = 4'(FRAME_FIXED_BITS + nbits + {3'h0, par_en} + {3'h0, fmt_q[FM_STOP2]});
  wire tx_bit_end = tx_busy_q && tick && (tx_smp_q == 5'(spb - 5'h1));
  wire tx_last = tx_bit_end && (tx_idx_q == 4'(tx_total - 4'h1));
  wire tx_par = ^(tx_sh_q & dmask) ^ fmt_q[FM_PAR_ODD];
  wire tx_in_data = (tx_idx_q != 4'h0) && (tx_idx_q <= nbits);
  wire tx_in_par = par_en && (tx_idx_q == 4'(nbits + 4'h1));
  wire [3:0] tx_dpos = 4'(tx_idx_q - 4'h1);
  wire tx_bit = (tx_idx_q == 4'h0) ? 1'b0 : tx_in_data ? tx_sh_q[tx_dpos] : tx_in_par ? tx_par : 1'b1;
  wire txc_set = tx_last && !tx_buf_vld_q; // see (RQ11)
  wire txc_clr = (wr_status && w_data_q[ST_TXC]) || irq_tx_ack;

  // Receiver
  wire rx_start = receiver_enable_q && !rx_busy_q && rx_prev_q && !rxd;
  wire rx_sample = rx_busy_q && tick && (rx_smp_q == 5'(half - 5'h1));
  wire rx_bit_end = rx_busy_q && tick && (rx_smp_q == 5'(spb - 5'h1));
  wire rx_in_data = (rx_idx_q != 4'h0) && (rx_idx_q <= nbits);
  wire rx_in_par = par_en && (rx_idx_q == 4'(nbits + 4'h1));
  wire rx_in_stop = (rx_idx_q == 4'(nbits + 4'h1 + {3'h0, par_en}));
  wire rx_false = rx_sample && (rx_idx_q == 4'h0) && rxd;
  wire rx_done = rx_sample && rx_in_stop;
  wire [3:0] rx_dpos = 4'(rx_idx_q - 4'h1);
  wire [8:0] rx_sh_d = (rx_sample && rx_in_data) ? (rx_sh_q | (9'(rxd) << rx_dpos)) : rx_sh_q; // see (RQ6)
  wire frame_type = (size_code == SIZE_9BIT) ? rx_sh_q[8] : rxd; // see (RQ23)
  wire rx_keep = rx_done && (!afm_q || frame_type) && !hold_vld_q; // see (RQ1)
  wire rx_upe = par_en && (^rx_sh_q ^ rx_pbit_q ^ fmt_q[FM_PAR_ODD]); // see (RQ15)
  wire dor_hit = rx_start && hold_vld_q && fifo_full; // see (RQ14)

  // Read mux; error bits are gated so a flushed FIFO shows none
  wire [7:0] status_rd = {receive_complete_flag, txc_q, tx_buffer_empty_flag, head.fe && receive_complete_flag, head.overrun_flag && receive_complete_flag, head.parity_error_flag && receive_complete_flag, u2x_q, afm_q}; // see (RQ13)
  wire [7:0] ctrl_rd = {receive_complete_irq_enable_q, transmit_complete_irq_enable_q, tx_empty_irq_enable_q, receiver_enable_q, transmitter_enable_q, szx_q, head.data[8] && receive_complete_flag, tx9_q};
  wire [7:0] data_rd = receive_complete_flag ? head.data[7:0] : 8'h00;
  wire [31:0] rd_mux = (ra == OFS_DATA) ? {24'h00_0000, data_rd} :
                       (ra == OFS_STATUS) ? {24'h00_0000, status_rd} :
                       (ra == OFS_CTRL) ? {24'h00_0000, ctrl_rd} :
                       (ra == OFS_FORMAT) ? {24'h00_0000, fmt_q} :
                       (ra == OFS_BAUD) ? {20'h0_0000, baud_q} :
                       (ra == OFS_IRQ) ? {31'h0, gie_q} : 32'h0000_0000;

  // Bus handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (aw_hs) begin
        awready_q <= 1'b0;
      end else if (b_hs) begin
        awready_q <= 1'b1;
      end
      if (w_hs) begin
        wready_q <= 1'b0;
      end else if (b_hs) begin
        wready_q <= 1'b1;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      end else if (b_hs) begin
        bvalid_q <= 1'b0;
      end
      if (ar_hs) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= is_mapped(ra) ? RESP_OKAY : RESP_SLVERR;
      end else if (r_hs) begin
        arready_q <= 1'b1;
        rvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_hs) begin
      aw_addr_q <= awaddr;
    end
    if (w_hs) begin
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
  end

  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {u2x_q, afm_q} <= {STATUS_RST[ST_U2X], STATUS_RST[ST_AFM]};
      txc_q <= STATUS_RST[ST_TXC];
      {receive_complete_irq_enable_q, transmit_complete_irq_enable_q, tx_empty_irq_enable_q, receiver_enable_q, transmitter_enable_q, szx_q, tx9_q} <= 7'h00;
      fmt_q <= 8'h00;
      baud_q <= 12'h000;
      gie_q <= 1'b0;
    end else begin
      if (wr_status) begin
        u2x_q <= w_data_q[ST_U2X];
        afm_q <= w_data_q[ST_AFM]; // see (RQ4)
      end
      txc_q <= txc_set || (txc_q && !txc_clr); // see (RQ11)
      if (wr_ctrl) begin
        {receive_complete_irq_enable_q, transmit_complete_irq_enable_q, tx_empty_irq_enable_q} <= {w_data_q[CT_RECEIVE_COMPLETE_IRQ_ENABLE], w_data_q[CT_TRANSMIT_COMPLETE_IRQ_ENABLE], w_data_q[CT_TX_EMPTY_IRQ_ENABLE]};
        {receiver_enable_q, transmitter_enable_q, szx_q} <= {w_data_q[CT_RECEIVER_ENABLE], w_data_q[CT_TRANSMITTER_ENABLE], w_data_q[CT_SZX]};
        tx9_q <= w_data_q[CT_TX9];
      end
      if (wr_format) begin
        fmt_q <= w_data_q[7:0] & FORMAT_MASK;
      end
      if (wr_baud_lo) begin
        baud_q[7:0] <= w_data_q[7:0];
      end
      if (wr_baud_hi) begin
        baud_q[BAUD_W-1:8] <= w_data_q[BAUD_W-1:8];
      end
      if (wr_irq) begin
        gie_q <= w_data_q[IRQ_GIE];
      end
    end
  end

  // Sample-rate prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 12'h000;
    end else begin
      pre_q <= tick ? baud_q : 12'(pre_q - 12'h001);
    end
  end

  // Transmit buffer and shifter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_vld_q <= 1'b0;
      tx_busy_q <= 1'b0;
      tx_on_q <= 1'b0;
      txd_q <= 1'b1;
      tx_idx_q <= 4'h0;
      tx_smp_q <= 5'h00;
    end else begin
      if (tx_take) begin
        tx_buf_q <= {tx9_q, w_data_q[7:0]} & dmask; // see (RQ22) see (RQ6)
        tx_buf_vld_q <= 1'b1;
      end else if (tx_load) begin
        tx_buf_vld_q <= 1'b0;
      end
      // Turning off waits for both shifter and buffer to drain
      tx_on_q <= transmitter_enable_q || (tx_on_q && (tx_busy_q || tx_buf_vld_q)); // see (RQ19)
      if (tx_load) begin
        tx_sh_q <= tx_buf_q;
        tx_busy_q <= 1'b1;
        tx_idx_q <= 4'h0;
        tx_smp_q <= 5'h00;
      end else if (tx_last) begin
        tx_busy_q <= 1'b0;
      end else if (tx_bit_end) begin
        tx_idx_q <= 4'(tx_idx_q + 4'h1);
        tx_smp_q <= 5'h00;
      end else if (tx_busy_q && tick) begin
        tx_smp_q <= 5'(tx_smp_q + 5'h01);
      end
      txd_q <= tx_busy_q ? tx_bit : 1'b1;
    end
  end

  // Receive shifter and holding stage in front of the FIFO
  always_ff @(posedge aclk) begin
    if (!aresetn || !receiver_enable_q) begin
      rx_busy_q <= 1'b0;
      rx_prev_q <= 1'b1;
      hold_vld_q <= 1'b0;
      dor_pend_q <= 1'b0;
      rx_idx_q <= 4'h0;
      rx_smp_q <= 5'h00;
      rx_sh_q <= 9'h000;
      rx_pbit_q <= 1'b0;
    end else begin
      rx_prev_q <= rxd;
      rx_sh_q <= rx_start ? 9'h000 : rx_sh_d;
      if (rx_sample && rx_in_par) begin
        rx_pbit_q <= rxd;
      end
      if (rx_start) begin
        rx_busy_q <= 1'b1;
        rx_idx_q <= 4'h0;
        rx_smp_q <= 5'h00;
      end else if (rx_false || rx_done) begin
        rx_busy_q <= 1'b0;
      end else if (rx_bit_end) begin
        rx_idx_q <= 4'(rx_idx_q + 4'h1);
        rx_smp_q <= 5'h00;
      end else if (rx_busy_q && tick) begin
        rx_smp_q <= 5'(rx_smp_q + 5'h01);
      end
      if (rx_keep) begin
        hold_q <= '{data: rx_sh_q & dmask, fe: !rxd, overrun_flag: 1'b0, parity_error_flag: rx_upe};
        hold_vld_q <= 1'b1;
      end else if (push) begin
        hold_vld_q <= 1'b0;
      end
      if (dor_hit) begin
        dor_pend_q <= 1'b1;
      end else if (push) begin
        dor_pend_q <= 1'b0;
      end
    end
  end

  // Interrupt requests and pin ownership
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_rx_q <= 1'b0;
      irq_tx_q <= 1'b0;
      irq_tx_buffer_empty_flag_q <= 1'b0;
    end else begin
      irq_rx_q <= gie_q && receive_complete_irq_enable_q && receive_complete_flag; // see (RQ17)
      irq_tx_q <= gie_q && transmit_complete_irq_enable_q && txc_q; // see (RQ17)
      irq_tx_buffer_empty_flag_q <= gie_q && tx_empty_irq_enable_q && tx_buffer_empty_flag; // see (RQ17)
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign txd = txd_q;
  assign txd_own = tx_on_q;
  assign rxd_own = receiver_enable_q; // see (RQ18)
  assign irq_rx = irq_rx_q;
  assign irq_tx = irq_tx_q;
  assign irq_tx_buffer_empty_flag = irq_tx_buffer_empty_flag_q;
endmodule // ubm_serial

/* File: sim/ubm_serial_assertions.sv */
// Port-level checker for ubm_serial, bound into every instance.
// Assumes the master offers write address and data together, as the bench does.
`timescale 1ns/1ps
module ubm_serial_assertions
  import ubm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ubm_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic txd,
  input wire logic txd_own,
  input wire logic rxd_own,
  input wire logic irq_rx,
  input wire logic irq_tx,
  input wire logic irq_tx_buffer_empty_flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] ctl_q;
  logic gie_q;
  wire wr_hit = awvalid && awready && wvalid && wready;
  // Shadow of the enables, seen only through the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= 8'h00;
      gie_q <= 1'b0;
    end else if (wr_hit && awaddr[5:2] == OFS_CTRL[5:2]) begin
      ctl_q <= wdata[7:0];
    end else if (wr_hit && awaddr[5:2] == OFS_IRQ[5:2]) begin
      gie_q <= wdata[IRQ_GIE];
    end
  end
  sequence s_wr_taken;
    wr_hit;
  endsequence
  sequence s_b_answer;
    !bvalid ##1 bvalid;
  endsequence
  property p_b_timing;
    s_wr_taken |=> s_b_answer;
  endproperty
  a_b_timing: assert property (p_b_timing) else $error("write answer late or early");
  property p_r_timing;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_r_timing: assert property (p_r_timing) else $error("read answer not next cycle");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_irq_rx;
    irq_rx |-> $past(ctl_q[CT_RECEIVE_COMPLETE_IRQ_ENABLE], 2) && $past(gie_q, 2);
  endproperty
  a_irq_rx: assert property (p_irq_rx) else $error("rx irq without enables");
  property p_irq_tx;
    irq_tx |-> $past(ctl_q[CT_TRANSMIT_COMPLETE_IRQ_ENABLE], 2) && $past(gie_q, 2);
  endproperty
  a_irq_tx: assert property (p_irq_tx) else $error("tx irq without enables");
  property p_irq_tx_buffer_empty_flag;
    irq_tx_buffer_empty_flag |-> $past(ctl_q[CT_TX_EMPTY_IRQ_ENABLE], 2) && $past(gie_q, 2);
  endproperty
  a_irq_tx_buffer_empty_flag: assert property (p_irq_tx_buffer_empty_flag) else $error("empty irq without enables");
  property p_line_owned;
    !txd |-> txd_own;
  endproperty
  a_line_owned: assert property (p_line_owned) else $error("frame sent on released pin");
  property p_tx_release;
    $fell(txd_own) |-> !$past(ctl_q[CT_TRANSMITTER_ENABLE]) && txd;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("tx pin released too soon");
  property p_rx_own;
    rxd_own |-> $past(ctl_q[CT_RECEIVER_ENABLE]) || $past(ctl_q[CT_RECEIVER_ENABLE], 2);
  endproperty
  a_rx_own: assert property (p_rx_own) else $error("rx pin owned while disabled");
endmodule // ubm_serial_assertions

bind ubm_serial ubm_serial_assertions chk_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wvalid,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .txd, .txd_own, .rxd_own,
  .irq_rx, .irq_tx, .irq_tx_buffer_empty_flag);

/* File: sim/ubm_remote_node.sv */
// Remote serial node: sends frames on rxd, decodes frames seen on txd.
// Assumes both ends use the same bit length in clocks and a settled txd.
`timescale 1ns/1ps
module ubm_remote_node #(
  parameter int BIT = 16
) (
  input wire logic aclk,
  input wire logic txd,
  input wire logic [3:0] nbits,
  output logic rxd,
  output logic [8:0] got,
  output logic got_stb
);
  logic [8:0] w;
  initial begin
    rxd = 1'b1;
    got = 9'h000;
    got_stb = 1'b0;
  end
  // Ninth bit carries the frame type in nine-bit mode
  task automatic send(input logic [8:0] d, input logic stop1);
    rxd <= 1'b0;
    repeat (BIT) @(posedge aclk);
    for (int i = 0; i < nbits; i++) begin
      rxd <= d[i];
      repeat (BIT) @(posedge aclk);
    end
    rxd <= stop1;
    repeat (BIT) @(posedge aclk);
    rxd <= 1'b1;
    repeat (BIT) @(posedge aclk);
  endtask
  always begin
    @(negedge txd);
    w = 9'h000;
    repeat (BIT / 2) @(posedge aclk);
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT) @(posedge aclk);
      w[i] = txd;
    end
    repeat (BIT) @(posedge aclk);
    got <= w;
    got_stb <= 1'b1;
    @(posedge aclk);
    got_stb <= 1'b0;
  end
endmodule // ubm_remote_node

/* File: sim/tb_ubm_serial.sv */
// Self-checking bench for ubm_serial with a remote node on the serial pins.
// Assumes the baud divisor 0, giving 16 clocks per bit.
`timescale 1ns/1ps
module tb_ubm_serial;
  import ubm_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, arvalid = 0, irq_tx_ack = 0, bready = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'h1;
  logic [3:0] nbits = 4'h8;
  logic awready, wready, bvalid, arready, rvalid, txd, txd_own, rxd_own, irq_rx, irq_tx, irq_tx_buffer_empty_flag, rxd, got_stb;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [8:0] got;
  logic [33:0] rd_q[$];
  logic [1:0] b_q[$];
  logic [8:0] tx_q[$];
  logic [7:0] v[4];
  int failures = 0, n_checks = 0;
  always #5 aclk = ~aclk;
  ubm_serial dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .rxd, .txd, .txd_own,
    .rxd_own, .irq_tx_ack, .irq_rx, .irq_tx, .irq_tx_buffer_empty_flag);
  ubm_remote_node #(.BIT(16)) remote_u (.aclk, .txd, .nbits, .rxd, .got, .got_stb);
  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    logic ad, wd;
    ad = 0;
    wd = 0;
    b_q.push_back(r);
    awaddr <= a;
    wdata <= {24'h0000_00, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (awready) begin
        ad = 1;
        awvalid <= 0;
      end
      if (wready) begin
        wd = 1;
        wvalid <= 0;
      end
    end
    // Late bready keeps the response-hold checks live
    repeat ($urandom_range(2)) @(posedge aclk);
    bready <= 1;
    do @(posedge aclk); while (!bvalid);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    rd_q.push_back({r, 24'h0000_00, d});
    araddr <= a;
    arvalid <= 1;
    rready <= 0;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    repeat ($urandom_range(2)) @(posedge aclk);
    rready <= 1;
    do @(posedge aclk); while (!rvalid);
  endtask
  // Completion flag sets only after the stop bit has fully ended
  task automatic drain;
    while (tx_q.size() != 0) @(posedge aclk);
    repeat (20) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    if (rvalid && rready) chk("rdata", rd_q.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("bresp", 34'(b_q.pop_front()), 34'(bresp));
    if (got_stb) chk("txd frame", 34'(tx_q.pop_front()), 34'(got));
  end
  initial begin
    repeat (30000) @(posedge aclk);
    failures++;
    finish_test;
  end
  initial begin
    void'($urandom(32'h5baedc40));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    rd(OFS_STATUS, 8'h20);
    rd(6'h18, 8'h00, RESP_SLVERR);
    wr(6'h18, 8'h00, RESP_SLVERR);
    wr(OFS_BAUD, 8'h00);
    wr(OFS_FORMAT, 8'h06);
    wr(OFS_IRQ, 8'h01);
    wr(OFS_CTRL, 8'hF8);
    foreach (v[i]) v[i] = 8'($urandom);
    tx_q.push_back({1'b0, v[0]});
    tx_q.push_back({1'b0, v[1]});
    wr(OFS_DATA, v[0]);
    wr(OFS_DATA, v[1]);
    wr(OFS_DATA, v[2]);
    drain;
    rd(OFS_STATUS, 8'h60);
    chk("irq", 34'h3, 34'({irq_rx, irq_tx, irq_tx_buffer_empty_flag}));
    irq_tx_ack <= 1;
    @(posedge aclk);
    irq_tx_ack <= 0;
    rd(OFS_STATUS, 8'h20);
    chk("irq", 34'h1, 34'({irq_rx, irq_tx, irq_tx_buffer_empty_flag}));
    $display("test transmit buffer done");
    foreach (v[i]) remote_u.send({1'b0, v[i]}, 1'b1);
    rd(OFS_DATA, v[0]);
    rd(OFS_STATUS, 8'hA0);
    rd(OFS_DATA, v[1]);
    rd(OFS_STATUS, 8'hA8);
    rd(OFS_DATA, v[2]);
    rd(OFS_STATUS, 8'h20);
    remote_u.send(9'h0C3, 1'b0);
    rd(OFS_STATUS, 8'hB0);
    rd(OFS_DATA, 8'hC3);
    $display("test receive fifo done");
    wr(OFS_FORMAT, 8'h00);
    nbits = 4'h5;
    // Divisor 1 with double speed keeps 16 clocks per bit
    wr(OFS_BAUD, 8'h01);
    wr(OFS_STATUS, 8'h02);
    remote_u.send(9'h0F5, 1'b1);
    rd(OFS_DATA, 8'h15);
    tx_q.push_back(9'h00A);
    wr(OFS_DATA, 8'hEA);
    drain;
    wr(OFS_STATUS, 8'h40);
    wr(OFS_BAUD, 8'h00);
    rd(OFS_STATUS, 8'h20);
    $display("test short characters done");
    wr(OFS_FORMAT, 8'h06);
    wr(OFS_CTRL, 8'hFC);
    nbits = 4'h9;
    wr(OFS_STATUS, 8'h01);
    remote_u.send(9'h055, 1'b1);
    remote_u.send(9'h1AA, 1'b1);
    rd(OFS_CTRL, 8'hFE);
    rd(OFS_DATA, 8'hAA);
    rd(OFS_STATUS, 8'h21);
    $display("test address filter done");
    remote_u.send(9'h1BB, 1'b1);
    rd(OFS_STATUS, 8'hA1);
    wr(OFS_CTRL, 8'hED);
    rd(OFS_STATUS, 8'h21);
    tx_q.push_back({1'b1, v[3]});
    wr(OFS_DATA, v[3]);
    wr(OFS_CTRL, 8'hE5);
    chk("txd_own", 34'h1, 34'(txd_own));
    drain;
    chk("pin own", 34'h0, 34'({txd_own, rxd_own}));
    $display("test disables done");
    finish_test;
  end
endmodule // tb_ubm_serial
